// ==== core/rx_two_entry_buffer.sv ====
/*
  Two-entry receive buffer with valid/ready on both sides.
  Assumes both sides run on the system clock with the same reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rx_two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire  logic             ref_clk,
  input  wire  logic             rst,
  // Filling side
  input  wire  logic [WIDTH-1:0] in_data,
  input  wire  logic             in_valid,
  output logic                   in_ready,
  // Draining side
  output logic [WIDTH-1:0]       out_data,
  output logic                   out_valid,
  input  wire  logic             out_ready
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic             push;
  logic             pop;

  // Handshakes on both sides
  assign in_ready  = (count_q != FULL_CNT);
  assign out_valid = (count_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_ptr_q];

  // Storage written on push
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  // Fill level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end

endmodule : rx_two_entry_buffer

`default_nettype wire

// ==== core/spi_cfg_pkg.sv ====
/*
  Constants for the SPI configuration and status register block:
  register address, bit positions, reset values, wiring modes.
  Assumes an 8-bit special function register port on the system clock.
*/
package spi_cfg_pkg;

  // Register address on the special function register port
  localparam logic [7:0] CFG_STATUS_ADDR = 8'hA1;

  // Bit positions inside the configuration and status register
  localparam int BUSY_BIT   = 7;
  localparam int ROLE_BIT   = 6;
  localparam int PHASE_BIT  = 5;
  localparam int POL_BIT    = 4;
  localparam int SEL_BIT    = 3;
  localparam int RAW_BIT    = 2;
  localparam int SHIFT_BIT  = 1;
  localparam int RXEMPT_BIT = 0;

  // Reset values of the register fields
  localparam logic BUSY_RST   = 1'b0;
  localparam logic ROLE_RST   = 1'b0;
  localparam logic PHASE_RST  = 1'b0;
  localparam logic POL_RST    = 1'b0;
  localparam logic SEL_RST    = 1'b0;
  localparam logic RAW_RST    = 1'b1;
  localparam logic SHIFT_RST  = 1'b1;
  localparam logic RXEMPT_RST = 1'b1;

  // Read data answered for an unmapped address
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // Slave-select wiring modes
  typedef enum logic [1:0] {
    WIRE_THREE      = 2'b00,
    WIRE_FOUR_IN    = 2'b01,
    WIRE_OUT_LOW    = 2'b10,
    WIRE_OUT_HIGH   = 2'b11
  } wiring_mode_t;

  // Serial data geometry
  localparam int BYTE_W     = 8;
  localparam int BIT_CNT_W  = 3;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Receive buffer depth
  localparam int RX_DEPTH = 2;

endpackage : spi_cfg_pkg

// ==== core/spi_config_status_register.sv ====
/*
  Configuration and status register of a byte-oriented SPI port,
  with the slave receive shifter on the serial clock, the select
  filter, the master input sampler and a two-entry receive buffer.
  Assumes control, clock divider and transmit path sit outside and
  drive the enable, wiring mode, buffer and divider inputs on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module spi_config_status_register (
  // System clock and reset
  input  wire  logic       ref_clk,
  input  wire  logic       rst,
  // Register port
  input  wire  logic [7:0] sfr_addr,
  input  wire  logic       sfr_wr,
  input  wire  logic       sfr_rd,
  input  wire  logic [7:0] sfr_wdata,
  output logic [7:0]       sfr_rdata_q,
  // Control signals from the control register
  input  wire  logic       port_enable,
  input  wire  logic [1:0] select_wiring_mode,
  // Transmit path and master divider state
  input  wire  logic       tx_load,
  input  wire  logic       tx_buffer_empty,
  input  wire  logic       master_busy,
  input  wire  logic       master_second_half,
  input  wire  logic [7:0] master_div_cnt,
  input  wire  logic [7:0] master_div_top,
  // Serial pins
  input  wire  logic       sck_link,
  input  wire  logic       mosi,
  input  wire  logic       miso,
  input  wire  logic       slave_select_n_i,
  output logic             slave_select_n_o_q,
  output logic             slave_select_n_oe_n_q,
  // Configuration outputs
  output logic             master_role_select_q,
  output logic             clock_phase_select_q,
  output logic             clock_polarity_select_q,
  // Master input sample
  output logic             master_rx_bit_q,
  output logic             master_rx_bit_valid_q,
  // Received byte stream
  output logic [7:0]       rx_data_q,
  output logic             rx_valid_q,
  input  wire  logic       rx_ready,
  output logic             rx_overrun_q
);

  //////////////////////////////////////////////////////////////////////////
  // Mode decode

  logic slave_active;
  logic four_wire_in;
  logic link_rst;
  logic sample_clk;

  assign slave_active = port_enable && !master_role_select_q;
  assign four_wire_in =
    (select_wiring_mode == spi_cfg_pkg::WIRE_FOUR_IN);

  // Link logic held idle when disabled or, in four-wire input mode, deselected
  assign link_rst = rst || !slave_active ||
                    (four_wire_in && slave_select_n_i);

  // Sampling edge: rising when polarity equals phase
  assign sample_clk = sck_link ^
    (clock_polarity_select_q ^ clock_phase_select_q);

  //////////////////////////////////////////////////////////////////////////
  // Link domain: receive shifter

  logic [6:0] link_shift_q;
  logic [2:0] link_bit_cnt_q;
  logic [7:0] link_hold_q;
  logic       link_done_tgl_q;

  // Data sampled on the edge centred in each bit
  always_ff @(posedge sample_clk or posedge link_rst) begin
    if (link_rst) begin
      link_shift_q   <= '0;
      link_bit_cnt_q <= '0;
    end else begin
      link_shift_q   <= {link_shift_q[5:0], mosi};
      link_bit_cnt_q <= link_bit_cnt_q + 1'b1;
    end
  end

  // Completed byte held for the crossing
  always_ff @(posedge sample_clk or posedge rst) begin
    if (rst) begin
      link_hold_q     <= '0;
      link_done_tgl_q <= 1'b0;
    end else if (!link_rst && link_bit_cnt_q == spi_cfg_pkg::LAST_BIT) begin
      link_hold_q     <= {link_shift_q, mosi};
      link_done_tgl_q <= ~link_done_tgl_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Crossings into the system clock domain

  logic [2:0] done_sync_q;
  logic [2:0] sck_sync_q;
  logic [1:0] sel_sync_q;
  logic [1:0] miso_sync_q;
  logic       byte_done;
  logic       sck_edge;

  // Two-flop synchronisers, plus an edge stage on the done toggle and serial clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_sync_q <= '0;
      sck_sync_q  <= '0;
      sel_sync_q  <= 2'b11;
      miso_sync_q <= '0;
    end else begin
      done_sync_q <= {done_sync_q[1:0], link_done_tgl_q};
      sck_sync_q  <= {sck_sync_q[1:0], sck_link};
      sel_sync_q  <= {sel_sync_q[0], slave_select_n_i};
      miso_sync_q <= {miso_sync_q[0], miso};
    end
  end

  assign byte_done = done_sync_q[2] ^ done_sync_q[1];
  assign sck_edge  = sck_sync_q[2] ^ sck_sync_q[1];

  //////////////////////////////////////////////////////////////////////////
  // Receive buffer

  logic [7:0] buf_out_data;
  logic       buf_out_valid;
  logic       buf_in_ready;
  logic       stage_ready;

  // Output stage accepts when empty or being drained
  assign stage_ready = !rx_valid_q || rx_ready;

  rx_two_entry_buffer #(
    .WIDTH (spi_cfg_pkg::BYTE_W),
    .DEPTH (spi_cfg_pkg::RX_DEPTH)
  ) u_rx_buf (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (link_hold_q),
    .in_valid  (byte_done),
    .in_ready  (buf_in_ready),
    .out_data  (buf_out_data),
    .out_valid (buf_out_valid),
    .out_ready (stage_ready)
  );

  // Registered stream output
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_data_q  <= '0;
      rx_valid_q <= 1'b0;
    end else if (stage_ready) begin
      rx_data_q  <= buf_out_data;
      rx_valid_q <= buf_out_valid;
    end
  end

  // Overrun pulse when the buffer cannot take a byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_overrun_q <= 1'b0;
    end else begin
      rx_overrun_q <= byte_done && !buf_in_ready;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration fields

  logic cfg_hit;

  assign cfg_hit = (sfr_addr == spi_cfg_pkg::CFG_STATUS_ADDR);

  // Writable role, phase and polarity bits
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      master_role_select_q    <= spi_cfg_pkg::ROLE_RST;
      clock_phase_select_q    <= spi_cfg_pkg::PHASE_RST;
      clock_polarity_select_q <= spi_cfg_pkg::POL_RST;
    end else if (sfr_wr && cfg_hit) begin
      master_role_select_q    <= sfr_wdata[spi_cfg_pkg::ROLE_BIT];
      clock_phase_select_q    <= sfr_wdata[spi_cfg_pkg::PHASE_BIT];
      clock_polarity_select_q <= sfr_wdata[spi_cfg_pkg::POL_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status state

  logic slave_busy_q;
  logic shift_empty_q;
  logic selected_filtered;
  logic transfer_busy;
  logic shift_empty;
  logic receive_empty;

  // Filtered select only, never the pin itself
  assign selected_filtered = !sel_sync_q[1];

  // Slave activity: set by edges leaving idle, so a trailing edge
  // after the last bit does not restart it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slave_busy_q <= spi_cfg_pkg::BUSY_RST;
    end else if (!slave_active || (four_wire_in && !selected_filtered)) begin
      slave_busy_q <= 1'b0;
    end else if (byte_done) begin
      slave_busy_q <= 1'b0;
    end else if (sck_edge && (sck_sync_q[1] != clock_polarity_select_q)) begin
      slave_busy_q <= 1'b1;
    end
  end

  assign transfer_busy = master_role_select_q ? master_busy
                                              : slave_busy_q;

  // Shift register empty; byte end beats the edge that closed it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_empty_q <= spi_cfg_pkg::SHIFT_RST;
    end else if (byte_done && tx_buffer_empty && !tx_load) begin
      shift_empty_q <= 1'b1;
    end else if (tx_load || sck_edge) begin
      shift_empty_q <= 1'b0;
    end
  end

  assign shift_empty   = master_role_select_q || shift_empty_q;
  assign receive_empty = master_role_select_q ||
                         !(rx_valid_q || buf_out_valid);

  //////////////////////////////////////////////////////////////////////////
  // Register read

  logic [7:0] status_word;

  // Raw select bit taken straight from the pin
  always_comb begin
    status_word = '0;
    status_word[spi_cfg_pkg::BUSY_BIT]   = transfer_busy;
    status_word[spi_cfg_pkg::ROLE_BIT]   = master_role_select_q;
    status_word[spi_cfg_pkg::PHASE_BIT]  = clock_phase_select_q;
    status_word[spi_cfg_pkg::POL_BIT]    = clock_polarity_select_q;
    status_word[spi_cfg_pkg::SEL_BIT]    = selected_filtered;
    status_word[spi_cfg_pkg::RAW_BIT]    = slave_select_n_i;
    status_word[spi_cfg_pkg::SHIFT_BIT]  = shift_empty;
    status_word[spi_cfg_pkg::RXEMPT_BIT] = receive_empty;
  end

  // Read data captured on the read strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata_q <= spi_cfg_pkg::UNMAPPED_RDATA;
    end else if (sfr_rd) begin
      sfr_rdata_q <= cfg_hit ? status_word : spi_cfg_pkg::UNMAPPED_RDATA;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Select pin driver

  // Output only in the 1x modes; enable low while driving
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slave_select_n_o_q    <= 1'b1;
      slave_select_n_oe_n_q <= 1'b1;
    end else begin
      slave_select_n_o_q    <= select_wiring_mode[0];
      slave_select_n_oe_n_q <= !select_wiring_mode[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Master input sampling

  logic master_sample_point;

  // Last system clock of the bit, one clock before its end
  assign master_sample_point = master_role_select_q && master_busy &&
    master_second_half && (master_div_cnt == master_div_top);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      master_rx_bit_q       <= 1'b0;
      master_rx_bit_valid_q <= 1'b0;
    end else begin
      master_rx_bit_valid_q <= master_sample_point;
      if (master_sample_point) begin
        master_rx_bit_q <= miso_sync_q[1];
      end
    end
  end

endmodule : spi_config_status_register

`default_nettype wire

// ==== verification/spi_cfg_properties.sv ====
/*
  Checker for the SPI configuration and status block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module spi_cfg_properties (
  // Clock, reset and register port
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata_q,
  // Select pin and role
  input wire logic       slave_select_n_i,
  input wire logic [1:0] select_wiring_mode,
  input wire logic       slave_select_n_oe_n_q,
  input wire logic       master_role_select_q,
  // Master sampler
  input wire logic       master_busy,
  input wire logic       master_second_half,
  input wire logic [7:0] master_div_cnt,
  input wire logic [7:0] master_div_top,
  input wire logic       master_rx_bit_valid_q,
  // Receive stream
  input wire logic [7:0] rx_data_q,
  input wire logic       rx_valid_q,
  input wire logic       rx_ready,
  input wire logic       rx_overrun_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Register port hits and a steady or just-changed select pin
  sequence rd_hit;
    sfr_rd && sfr_addr == spi_cfg_pkg::CFG_STATUS_ADDR;
  endsequence
  sequence sel_steady;
    $stable(slave_select_n_i)[*4] ##0 rd_hit;
  endsequence
  sequence sel_jump;
    $stable(slave_select_n_i)[*3] ##1 ($changed(slave_select_n_i) ##0 rd_hit);
  endsequence

  a_role_write: assert property (sfr_wr && sfr_addr == 8'hA1 |=>
    master_role_select_q == $past(sfr_wdata[6])) else $error("role bit");
  a_raw_pin: assert property (rd_hit |=>
    sfr_rdata_q[2] == $past(slave_select_n_i)) else $error("raw bit");
  a_master_empty: assert property (rd_hit ##0
    master_role_select_q |=> sfr_rdata_q[1:0] == 2'h3)
    else $error("master empty bits");
  a_sel_filtered: assert property (sel_steady |=>
    sfr_rdata_q[3] == !slave_select_n_i) else $error("selected bit");
  a_sel_no_glitch: assert property (sel_jump |=>
    sfr_rdata_q[3] == !$past(slave_select_n_i, 2)) else $error("glitch");
  a_oe_drive: assert property (select_wiring_mode[1] &&
    $stable(select_wiring_mode) |=> !slave_select_n_oe_n_q) else $error("oe");
  a_master_sample: assert property (master_role_select_q &&
    master_busy && master_second_half && master_div_cnt == master_div_top
    |=> master_rx_bit_valid_q) else $error("master sample");
  a_rx_stall_hold: assert property (rx_valid_q && !rx_ready |=>
    rx_valid_q && $stable(rx_data_q)) else $error("stall lost word");
  a_overrun_pulse: assert property (rx_overrun_q |=> !rx_overrun_q)
    else $error("overrun pulse");
endmodule : spi_cfg_properties

bind spi_config_status_register spi_cfg_properties chk_u (
  .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
  .slave_select_n_i(slave_select_n_i),
  .select_wiring_mode(select_wiring_mode),
  .slave_select_n_oe_n_q(slave_select_n_oe_n_q),
  .master_role_select_q(master_role_select_q), .master_busy(master_busy),
  .master_second_half(master_second_half),
  .master_div_cnt(master_div_cnt), .master_div_top(master_div_top),
  .master_rx_bit_valid_q(master_rx_bit_valid_q), .rx_data_q(rx_data_q),
  .rx_valid_q(rx_valid_q), .rx_ready(rx_ready),
  .rx_overrun_q(rx_overrun_q));

`default_nettype wire

// ==== verification/spi_far_master.sv ====
/*
  Far-side SPI master model driving clock, data and select.
  Assumes the bench calls its tasks; link clock period 125 ns.
*/
`timescale 1ns/1ps
`default_nettype none

module spi_far_master (
  // Serial pins
  output var logic sck_link,
  output var logic mosi,
  output var logic slave_select_n
);
  ////////////////////////////////////////
  // Pins at rest, select released
  initial begin
    sck_link = 1'b0;
    mosi = 1'b1;
    slave_select_n = 1'b1;
  end
  // Clock rest level and select level
  task automatic frame(input logic sel_n, input logic pol);
    sck_link = pol;
    slave_select_n = sel_n;
  endtask : frame
  // One byte MSB first; clock moves only inside the frame
  task automatic send_byte(input logic [7:0] b, input logic pol,
                           input logic pha);
    for (int i = 7; i >= 0; i--) begin
      if (pha) sck_link = !pol;
      mosi = b[i];
      #62.5 sck_link = pha ? pol : !pol;
      #62.5 sck_link = pol;
    end
    mosi = !mosi; // Released line shows no stale bit
  endtask : send_byte
endmodule : spi_far_master

`default_nettype wire

// ==== verification/tb.sv ====
/*
  Self-checking bench for the SPI configuration and status block.
  Assumes the far master model and the bound checker beside it.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic       ref_clk, rst, sfr_wr, sfr_rd, port_enable, tx_load;
  logic       tx_buffer_empty, master_busy, master_second_half;
  logic       miso, rx_ready, ssn_o, ssn_oe_n, role_q, pha_q, pol_q;
  logic       mbit, mbit_v, rx_valid, rx_ovr, ovr_seen;
  logic [7:0] sfr_addr, sfr_wdata, div_cnt, div_top, rdata, rx_data, rd;
  logic [1:0] mode;
  wire  logic sck, mosi, far_ssn, ssn_pin;
  int         fail_count, n_checks;
  ////////////////////////////////////////
  // Select pin level from both parties
  assign ssn_pin = ssn_oe_n ? far_ssn : ssn_o;
  spi_far_master far_u (.sck_link(sck), .mosi(mosi),
    .slave_select_n(far_ssn));
  spi_config_status_register dut_u (.ref_clk(ref_clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(rdata), .port_enable(port_enable),
    .select_wiring_mode(mode), .tx_load(tx_load),
    .tx_buffer_empty(tx_buffer_empty), .master_busy(master_busy),
    .master_second_half(master_second_half), .master_div_cnt(div_cnt),
    .master_div_top(div_top), .sck_link(sck), .mosi(mosi), .miso(miso),
    .slave_select_n_i(ssn_pin), .slave_select_n_o_q(ssn_o),
    .slave_select_n_oe_n_q(ssn_oe_n), .master_role_select_q(role_q),
    .clock_phase_select_q(pha_q), .clock_polarity_select_q(pol_q),
    .master_rx_bit_q(mbit), .master_rx_bit_valid_q(mbit_v),
    .rx_data_q(rx_data), .rx_valid_q(rx_valid), .rx_ready(rx_ready),
    .rx_overrun_q(rx_ovr));
  // System clock and overrun watch
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (rx_ovr === 1'b1) ovr_seen <= 1'b1;

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic reg_acc(input logic w, input logic [7:0] a,
                         input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    step(1);
    rd = rdata;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    step(1);
  endtask : reg_acc
  task automatic wait_rx(input logic [7:0] exp);
    int i;
    for (i = 0; i < 400 && rx_valid !== 1'b1; i++) step(1);
    if (i == 400) begin
      $display("ERROR %0t no received byte", $time);
      fail_count++;
      end_sim();
    end else begin
      check(rx_data, exp);
      rx_ready = 1'b1;
      step(1);
      rx_ready = 1'b0;
      step(1);
    end
  endtask : wait_rx
  ////////////////////////////////////////
  // Reset word, master role, unmapped read, master sampler
  task automatic t_master();
    int i;
    reg_acc(1'b0, 8'hA1, 8'h00);
    check(rd, 8'h07);
    reg_acc(1'b1, 8'hA1, 8'hF0);
    reg_acc(1'b0, 8'hA1, 8'h00);
    check(rd, 8'h77);
    reg_acc(1'b0, 8'hA2, 8'h00);
    check(rd, 8'h00);
    {master_busy, master_second_half, div_cnt, div_top} = {2'h3, 16'h0505};
    step(1);
    master_busy = 1'b0;
    for (i = 0; i < 4 && mbit_v !== 1'b1; i++) step(1);
    check({6'h00, mbit_v, mbit}, 8'h03);
  endtask : t_master
  // Wiring modes, filtered and raw select, transmit load
  task automatic t_select();
    reg_acc(1'b1, 8'hA1, 8'h00);
    port_enable = 1'b1;
    for (int m = 0; m < 4; m++) begin
      mode = 2'(m);
      step(3);
      check({6'h00, ssn_oe_n, ssn_o}, {6'h00, !mode[1], mode[0]});
    end
    mode = 2'h1;
    step(5);
    far_u.frame(1'b0, 1'b0);
    reg_acc(1'b0, 8'hA1, 8'h00);
    check(rd & 8'h0C, 8'h00);
    step(4);
    reg_acc(1'b0, 8'hA1, 8'h00);
    check(rd & 8'h0C, 8'h08);
    {tx_buffer_empty, tx_load} = 2'h1;
    step(1);
    {tx_buffer_empty, tx_load} = 2'h2;
    reg_acc(1'b0, 8'hA1, 8'h00);
    check(rd & 8'h02, 8'h00);
  endtask : t_select
  // Four bytes with the reader stalled, then drained
  task automatic t_stream();
    ovr_seen = 1'b0;
    for (int i = 1; i < 5; i++) far_u.send_byte(8'(i * 17), 1'b0, 1'b0);
    step(20);
    check({7'h00, ovr_seen}, 8'h01);
    reg_acc(1'b0, 8'hA1, 8'h00);
    check(rd & 8'h81, 8'h00);
    for (int i = 1; i < 4; i++) wait_rx(8'(i * 17));
    step(6);
    reg_acc(1'b0, 8'hA1, 8'h00);
    check(rd & 8'h01, 8'h01);
  endtask : t_stream
  // Phase and polarity set while disabled, busy seen mid-byte
  task automatic t_phase();
    port_enable = 1'b0;
    far_u.frame(1'b1, 1'b1);
    reg_acc(1'b1, 8'hA1, 8'h30);
    port_enable = 1'b1;
    far_u.frame(1'b0, 1'b1);
    step(5);
    fork
      far_u.send_byte(8'h3C, 1'b1, 1'b1);
      begin
        step(25);
        reg_acc(1'b0, 8'hA1, 8'h00);
        check(rd & 8'h80, 8'h80);
      end
    join
    wait_rx(8'h3C);
    reg_acc(1'b0, 8'hA1, 8'h00);
    check(rd & 8'h83, 8'h03);
  endtask : t_phase

  initial begin
    {rst, sfr_wr, sfr_rd, port_enable, tx_load, master_busy} = 6'h20;
    {tx_buffer_empty, master_second_half, miso, rx_ready} = 4'hA;
    {sfr_addr, sfr_wdata, div_cnt, div_top, mode} = {32'h0, 2'h1};
    {fail_count, n_checks, ovr_seen} = '0;
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    step(2);
    t_master();
    t_select();
    t_stream();
    t_phase();
    end_sim();
  end
endmodule : tb

`default_nettype wire
